/* bench/fault_line_peer.sv */
/* peer manager pulls on the three shared fault wires, plus the wire pull-up.
   assumes the design's enable pulls the wire low only while its out is low. */
`timescale 1ns/100ps
module fault_line_peer (
  // pulls from the design and from the peer
  input wire [2:0] dut_oe,
  input wire [2:0] dut_out,
  input wire [2:0] peer_pull,
  // resolved wire level, active low
  output wire [2:0] level_n
);
  // wired-and: a released wire rises to the pull-up level, never holds old data
  // an enabled pad that shows a high level does not pull the wire
  assign level_n = ~((dut_oe & ~dut_out) | peer_pull);
endmodule // fault_line_peer

/* bench/pin_control_checker.sv */
/* assertions on the pin control top ports.
   assumes the bench never drops MONITOR_ON while RECALL_DONE stays high. */
`timescale 1ns/100ps
module pin_control_checker #(parameter NEN = 12, parameter NMG = 8) (
  // inputs of the design
  input wire CLK, input wire RST, input wire RECALL_DONE, input wire MONITOR_ON,
  input wire [NEN-1:0] SUPPLY_ON, input wire [NEN-1:0] CHAN_FAULT,
  input wire [NEN*4-1:0] ENABLE_OUTPUT_CONFIG_CMD, input wire [NEN*6-1:0] FAULT_ACTION_CMD,
  input wire [NMG*4-1:0] MARGIN_OUTPUT_CONFIG_CMD, input wire [NMG*8-1:0] MARGIN_DUTY,
  input wire [2:0] SHARED_FAULT_LINE_N_IN,
  // outputs of the design
  input wire [NEN-1:0] SUPPLY_ENABLE_OUT, input wire [NEN-1:0] SUPPLY_ENABLE_OE,
  input wire [NMG-1:0] MARGIN_PULSE_OUT, input wire [NMG-1:0] MARGIN_PULSE_OE,
  input wire [2:0] SHARED_FAULT_LINE_N_OE, input wire [NEN-1:0] CHAN_SHUTDOWN);
  reg [1:0] run_age;
  reg [2:0] drv;
  integer i;
  wire [3:0] ec = ENABLE_OUTPUT_CONFIG_CMD[3:0];
  wire [3:0] mc = MARGIN_OUTPUT_CONFIG_CMD[3:0];
  // a tripped channel counts as off
  wire lv0 = ec[2] ? ec[3] : ((SUPPLY_ON[0] & ~CHAN_SHUTDOWN[0]) ~^ ec[0]);
  wire od_hi0 = !ec[1] && lv0;
  wire hit0 = |(~SHARED_FAULT_LINE_N_IN & FAULT_ACTION_CMD[5:3]);
  // two edges with recall and monitor up guarantee the run state
  always @(posedge CLK)
    if (RST || !(RECALL_DONE && MONITOR_ON)) run_age <= 2'h0;
    else if (run_age != 2'h3) run_age <= run_age + 2'h1;
  // lines that faulted channels ask to pull
  always @* begin
    drv = 3'h0;
    for (i = 0; i < NEN; i = i + 1)
      if (CHAN_FAULT[i]) drv = drv | FAULT_ACTION_CMD[i*6 +: 3];
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_reset_float: assert property (disable iff (1'b0) RST |=>
    ~|{SHARED_FAULT_LINE_N_OE, SUPPLY_ENABLE_OE, MARGIN_PULSE_OE}) else $error("pin driven in reset");
  a_recall_pull: assert property (!RECALL_DONE ##1 (RECALL_DONE && !MONITOR_ON)
    |=> ##1 SHARED_FAULT_LINE_N_OE == 3'h7) else $error("fault lines not held after recall");
  a_fault_drive: assert property (run_age == 2'h3 |=> SHARED_FAULT_LINE_N_OE == $past(drv))
    else $error("fault line drive wrong");
  a_shutdown_cause: assert property ($rose(CHAN_SHUTDOWN[0]) |-> $past(hit0, 3))
    else $error("shutdown without synced cause");
  a_margin_float: assert property ($stable(mc) && !mc[0] && !mc[1] |-> !MARGIN_PULSE_OE[0])
    else $error("margin pin driven while off");
  a_full_duty: assert property ((mc == 4'h1 && MARGIN_DUTY[7:0] == 8'hff) [*3]
    |-> !MARGIN_PULSE_OE[0] || MARGIN_PULSE_OUT[0]) else $error("full duty went low");
  a_enable_level: assert property (SUPPLY_ENABLE_OE[0] |-> SUPPLY_ENABLE_OUT[0] == $past(lv0))
    else $error("enable level wrong");
  a_open_drain: assert property ($past(od_hi0) |-> !SUPPLY_ENABLE_OE[0])
    else $error("open drain drove high");
  c_run_fault: cover property (run_age == 2'h3 && |drv);
  c_shutdown: cover property ($rose(CHAN_SHUTDOWN[0]));
  c_full_duty: cover property (mc == 4'h1 && MARGIN_DUTY[7:0] == 8'hff);
endmodule // pin_control_checker
bind supply_enable_fault_pin_control pin_control_checker #(.NEN(NEN), .NMG(NMG)) u_chk (.*);

/* bench/supply_enable_fault_pin_control_tb_top.sv */
/* self-checking bench for the pin control block.
   assumes the peer model resolves the fault wires. */
`timescale 1ns/100ps
module supply_enable_fault_pin_control_tb_top;
  reg clk = 1'b0, rst = 1'b1, recall = 1'b0, monitor = 1'b0;
  reg [11:0] on = 12'h0, cf = 12'h0;
  reg [47:0] ecfg = 48'h0;
  reg [71:0] fcfg = 72'h0;
  reg [31:0] mcfg = 32'h0;
  reg [63:0] duty = 64'h0;
  reg [95:0] rnd;
  reg [2:0] peer = 3'h0;
  wire [11:0] en_out, en_oe, sd;
  wire [7:0] mg_out, mg_oe;
  wire [2:0] fl_in, fl_oe, fl_out;
  integer num_errors = 0, num_checks = 0, cyc = 0, k, lo, hi;
  always #5 clk = ~clk;
  supply_enable_fault_pin_control u_supply_enable_fault_pin_control (.CLK(clk), .RST(rst),
    .RECALL_DONE(recall), .MONITOR_ON(monitor), .SUPPLY_ON(on), .CHAN_FAULT(cf),
    .ENABLE_OUTPUT_CONFIG_CMD(ecfg), .FAULT_ACTION_CMD(fcfg), .MARGIN_OUTPUT_CONFIG_CMD(mcfg),
    .MARGIN_DUTY(duty), .SUPPLY_ENABLE_OUT(en_out), .SUPPLY_ENABLE_OE(en_oe),
    .MARGIN_PULSE_OUT(mg_out), .MARGIN_PULSE_OE(mg_oe), .SHARED_FAULT_LINE_N_IN(fl_in),
    .SHARED_FAULT_LINE_N_OUT(fl_out), .SHARED_FAULT_LINE_N_OE(fl_oe), .CHAN_SHUTDOWN(sd));
  fault_line_peer u_fault_line_peer (.dut_oe(fl_oe), .dut_out(fl_out), .peer_pull(peer),
    .level_n(fl_in));
  // ==========================================================
  // checking helpers
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // inputs always change 1 ns after an edge, so sampling never races
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  // {driven high, drive enable} per enable pin
  function [23:0] exp_en(input [47:0] c, input [11:0] s);
    integer j;
    reg lv;
    begin
      for (j = 0; j < 12; j = j + 1) begin
        lv = c[j*4+2] ? c[j*4+3] : (s[j] ~^ c[j*4]);
        exp_en[j] = c[j*4+1] | ~lv;
        exp_en[12+j] = lv & c[j*4+1];
      end
    end
  endfunction
  function [2:0] exp_flt(input [11:0] f, input [71:0] a);
    integer j;
    begin
      exp_flt = 3'h0;
      for (j = 0; j < 12; j = j + 1) if (f[j]) exp_flt = exp_flt | a[j*6 +: 3];
    end
  endfunction
  // margin off: only the general output drive may show
  function [15:0] exp_mg(input [31:0] m);
    integer j;
    begin
      for (j = 0; j < 8; j = j + 1) begin
        exp_mg[j] = m[j*4+1] & m[j*4+3];
        exp_mg[8+j] = exp_mg[j] & m[j*4+2];
      end
    end
  endfunction
  // hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  initial begin
    k = $urandom(32'h1d74a5e4);
    cf = 12'hfff;
    fcfg = {12{6'h07}};
    tick(2);
    chk("reset", {en_oe, mg_oe, fl_oe}, 32'h0);
    rst = 1'b0;
    tick(3);
    chk("hold", {en_oe, mg_oe, fl_oe}, 32'h0);
    cf = 12'h0;
    recall = 1'b1;
    tick(2);
    chk("recall", fl_oe, 32'h7);
    monitor = 1'b1;
    tick(2);
    chk("release", fl_oe, 32'h0);
    $display("test power-up done");
    for (k = 0; k < 24; k = k + 1) begin
      rnd = {$urandom, $urandom, $urandom};
      {cf, on} = rnd[23:0];
      ecfg = (k == 0) ? {12{4'he}} : rnd[71:24];
      mcfg = rnd[95:64] & {8{4'he}};
      duty = rnd[63:0];
      fcfg = {rnd[47:0], rnd[95:72]} & {12{6'h07}};
      tick(2);
      chk("fault_oe", fl_oe, exp_flt(cf, fcfg));
      chk("fault_out", fl_out, 32'h0);
      chk("enable", {en_out & en_oe, en_oe}, exp_en(ecfg, on));
      chk("margin", {mg_out & mg_oe, mg_oe}, exp_mg(mcfg));
    end
    $display("test random done");
    cf = 12'h0;
    fcfg = 72'h0;
    // let the last random drive leave the wires and the synchroniser
    tick(4);
    fcfg = 72'h800000020;
    peer = 3'h4;
    tick(2);
    chk("sync", sd, 32'h0);
    tick(1);
    chk("shutdown", sd, 32'h021);
    peer = 3'h0;
    tick(2);
    chk("sticky", sd, 32'h021);
    $display("test shutdown done");
    mcfg = 32'h11;
    duty = 64'h80ff;
    lo = 0;
    hi = 0;
    tick(3);
    repeat (256) begin
      lo = lo + !mg_out[0];
      hi = hi + mg_out[1];
      tick(1);
    end
    chk("full", lo, 32'h0);
    chk("half", hi, 32'h80);
    chk("margin_oe", mg_oe, 32'h03);
    $display("test duty done");
    cf = 12'hfff;
    fcfg = {12{6'h07}};
    recall = 1'b0;
    tick(2);
    chk("cycle", {en_oe, mg_oe, fl_oe}, 32'h0);
    $display("test power cycle done");
    tally_and_finish;
  end
endmodule // supply_enable_fault_pin_control_tb_top

/* hdl/margin_pulse_gen.v */
/*
  one margin pulse channel: free running counter compared against a duty word.
  assumes duty is stable per period; full scale holds the pin high.
*/
`timescale 1ns/100ps
`include "pin_control_map.vh"

module margin_pulse_gen #(
  parameter DW = `DUTY_W
) (
  // clock and reset
  input wire CLK,
  input wire RST,
  // control
  input wire [DW-1:0] DUTY,
  // pulse
  output reg PULSE
);

  reg [DW-1:0] count;

  // ==========================================================
  // counter and compare
  // full scale never goes low, so the counter wrap is not seen at the pin
  always @(posedge CLK) begin
    if (RST) begin
      count <= {DW{1'b0}};
      PULSE <= 1'b0;
    end else begin
      count <= count + {{(DW-1){1'b0}}, 1'b1};
      PULSE <= (DUTY == {DW{1'b1}}) ? 1'b1 : (count < DUTY);
    end
  end

endmodule // margin_pulse_gen

/* hdl/pin_control_map.vh */
/*
  constants for the supply-enable, margin pulse and shared fault pin control.
  assumes inclusion by the pin control modules only; definitions only.
*/
`ifndef PIN_CONTROL_MAP_VH
`define PIN_CONTROL_MAP_VH

// ==========================================================
// enable output config field positions (per channel, 4 bits)
`define ENCFG_W 4
`define ENCFG_POL 0
`define ENCFG_PP 1
`define ENCFG_GEN 2
`define ENCFG_GENVAL 3

// ==========================================================
// margin output config field positions (per channel, 4 bits)
`define MGCFG_W 4
`define MGCFG_EN 0
`define MGCFG_GEN 1
`define MGCFG_GENVAL 2
`define MGCFG_GENOE 3

// ==========================================================
// pulse width modulator
`define DUTY_W 8
`define DUTY_FULL 8'hff
`define DUTY_ZERO 8'h00

// ==========================================================
// fault lines
`define FLINES 3
`define FLINES_NONE 3'h0

`endif

/* hdl/supply_enable_fault_pin_control.v */
/*
  pin control for supply-enable outputs, margin pulse outputs and the three
  shared open-drain fault lines of a supply manager.
  assumes all inputs but the fault lines synchronous to CLK; configuration arrives as levels from
  the command interface; pad wiring resolves the open-drain lines.
  assumes external pull-ups on the fault lines and on open-drain enables.
*/
`timescale 1ns/100ps
`include "pin_control_map.vh"

module supply_enable_fault_pin_control #(
  parameter NEN = 12,
  parameter NMG = 8
) (
  // clock and reset
  input wire CLK,
  input wire RST,
  // power-up status
  input wire RECALL_DONE,
  input wire MONITOR_ON,
  // sequencer requests, one per enable channel
  input wire [NEN-1:0] SUPPLY_ON,
  input wire [NEN-1:0] CHAN_FAULT,
  // enable output config: 4 bits per channel
  input wire [NEN*`ENCFG_W-1:0] ENABLE_OUTPUT_CONFIG_CMD,
  // fault action: 3 drive bits then 3 shutdown select bits per channel
  input wire [NEN*2*`FLINES-1:0] FAULT_ACTION_CMD,
  // margin config and duty
  input wire [NMG*`MGCFG_W-1:0] MARGIN_OUTPUT_CONFIG_CMD,
  input wire [NMG*`DUTY_W-1:0] MARGIN_DUTY,
  // supply enable pins
  output reg [NEN-1:0] SUPPLY_ENABLE_OUT,
  output reg [NEN-1:0] SUPPLY_ENABLE_OE,
  // margin pins
  output reg [NMG-1:0] MARGIN_PULSE_OUT,
  output reg [NMG-1:0] MARGIN_PULSE_OE,
  // shared fault lines, active low open drain
  input wire [`FLINES-1:0] SHARED_FAULT_LINE_N_IN,
  output reg [`FLINES-1:0] SHARED_FAULT_LINE_N_OUT,
  output reg [`FLINES-1:0] SHARED_FAULT_LINE_N_OE,
  // per channel shutdown status
  output reg [NEN-1:0] CHAN_SHUTDOWN
);

  // power-up phases, one-hot
  localparam [2:0] ST_HOLD = 3'h1;
  localparam [2:0] ST_RECALLED = 3'h2;
  localparam [2:0] ST_RUN = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [`FLINES-1:0] fault_meta;
  reg [`FLINES-1:0] fault_sync;
  // combinational merge of channel requests
  reg [`FLINES-1:0] fault_drive;
  reg [NEN-1:0] next_shut;
  wire [NMG-1:0] pulse;
  integer i;

  // pick the drive bits of a channel's fault action field
  function [`FLINES-1:0] drive_sel;
    input [2*`FLINES-1:0] f;
    begin
      drive_sel = f[`FLINES-1:0];
    end
  endfunction

  // pick the shutdown select bits of a channel's fault action field
  function [`FLINES-1:0] shut_sel;
    input [2*`FLINES-1:0] f;
    begin
      shut_sel = f[2*`FLINES-1:`FLINES];
    end
  endfunction

  // ==========================================================
  // power-up sequence
  // recall dropping is treated as a power cycle from any phase, so the
  // fault lines are never left pulled low while the part restarts
  always @* begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (RECALL_DONE) next_state = ST_RECALLED;
      end
      ST_RECALLED: begin
        // a power cycle before monitoring starts goes straight back to hold
        if (!RECALL_DONE) next_state = ST_HOLD;
        else if (MONITOR_ON) next_state = ST_RUN;
      end
      ST_RUN: begin
        if (!RECALL_DONE) next_state = ST_HOLD;
      end
      default: next_state = ST_HOLD;
    endcase
  end

  always @(posedge CLK) begin
    if (RST) state <= ST_HOLD;
    else state <= next_state;
  end

  // ==========================================================
  // fault line sensing; first stage read only by the second
  // peers pull these wires on their own clocks, hence two stages
  always @(posedge CLK) begin
    if (RST) begin
      fault_meta <= `FLINES_NONE;
      fault_sync <= `FLINES_NONE;
    end else begin
      fault_meta <= ~SHARED_FAULT_LINE_N_IN;
      fault_sync <= fault_meta;
    end
  end

  // ==========================================================
  // fault drive merge and shutdown decision
  // own drive is also sensed back, so a channel may trip on its own line
  // a channel with an empty drive field pulls no line even when faulted
  always @* begin
    fault_drive = `FLINES_NONE;
    next_shut = {NEN{1'b0}};
    for (i = 0; i < NEN; i = i + 1) begin
      if (CHAN_FAULT[i])
        fault_drive = fault_drive |
          drive_sel(FAULT_ACTION_CMD[i*2*`FLINES +: 2*`FLINES]);
      next_shut[i] = |(fault_sync &
        shut_sel(FAULT_ACTION_CMD[i*2*`FLINES +: 2*`FLINES]));
    end
  end

  // ==========================================================
  // fault line pins: release in reset, low after recall, then per fault
  // the out register stays zero so an enabled pad can only pull low
  always @(posedge CLK) begin
    SHARED_FAULT_LINE_N_OUT <= `FLINES_NONE; // open drain only ever pulls low
    if (RST) begin
      SHARED_FAULT_LINE_N_OE <= `FLINES_NONE;
    end else if (state == ST_RECALLED) begin
      SHARED_FAULT_LINE_N_OE <= {`FLINES{1'b1}};
    end else if (state == ST_RUN) begin
      SHARED_FAULT_LINE_N_OE <= fault_drive;
    end else begin
      SHARED_FAULT_LINE_N_OE <= `FLINES_NONE;
    end
  end

  // ==========================================================
  // shutdown latch: sticky until reset, kept through a recall power cycle
  // limitation: a line that asserts and clears before the last two edges up to run entry is never latched
  always @(posedge CLK) begin
    if (RST) CHAN_SHUTDOWN <= {NEN{1'b0}};
    else if (state == ST_RUN) CHAN_SHUTDOWN <= CHAN_SHUTDOWN | next_shut;
  end

  // ==========================================================
  // supply enable pins
  // pins float in hold, so external pulls keep supplies off until recall
  genvar g;
  generate
    for (g = 0; g < NEN; g = g + 1) begin : gen_en
      wire [`ENCFG_W-1:0] cfg = ENABLE_OUTPUT_CONFIG_CMD[g*`ENCFG_W +: `ENCFG_W];
      // a tripped channel reads as off whatever the sequencer asks
      wire on = SUPPLY_ON[g] & ~CHAN_SHUTDOWN[g];
      wire lvl = cfg[`ENCFG_GEN] ? cfg[`ENCFG_GENVAL] : (on ~^ cfg[`ENCFG_POL]);
      always @(posedge CLK) begin
        if (RST || state == ST_HOLD) begin
          SUPPLY_ENABLE_OUT[g] <= 1'b0;
          SUPPLY_ENABLE_OE[g] <= 1'b0;
        end else begin
          SUPPLY_ENABLE_OUT[g] <= lvl;
          // open drain drives only the low level
          SUPPLY_ENABLE_OE[g] <= cfg[`ENCFG_PP] | ~lvl;
        end
      end
    end
  endgenerate

  // ==========================================================
  // margin pulse pins
  // generators run on through hold, so the first period after recall starts mid-count
  generate
    for (g = 0; g < NMG; g = g + 1) begin : gen_mg
      wire [`MGCFG_W-1:0] cfg = MARGIN_OUTPUT_CONFIG_CMD[g*`MGCFG_W +: `MGCFG_W];
      margin_pulse_gen #(.DW(`DUTY_W)) u_pwm (
        .CLK(CLK),
        .RST(RST),
        .DUTY(MARGIN_DUTY[g*`DUTY_W +: `DUTY_W]),
        .PULSE(pulse[g])
      );
      always @(posedge CLK) begin
        if (RST || state == ST_HOLD) begin
          MARGIN_PULSE_OUT[g] <= 1'b0;
          MARGIN_PULSE_OE[g] <= 1'b0;
        end else if (cfg[`MGCFG_GEN]) begin
          MARGIN_PULSE_OUT[g] <= cfg[`MGCFG_GENVAL];
          MARGIN_PULSE_OE[g] <= cfg[`MGCFG_GENOE];
        end else begin
          MARGIN_PULSE_OUT[g] <= pulse[g];
          MARGIN_PULSE_OE[g] <= cfg[`MGCFG_EN];
        end
      end
    end
  endgenerate

endmodule // supply_enable_fault_pin_control
